// [hw/disc_drive_tag_command_decoder.sv]
// tag bus command decoder with a classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "drive_cmd_map.svh"

// Notes on behaviour
// - execute decoded tag command on strobe
// - command is four-bit tag code
// - control lines captured when strobe rises
// - record address loads sector from bits 5:0
// - record address loads head from bits 9:8
// - unit address enables only on match
// - unit number comes from panel selector
// - clear status bit0 clears attention flops
// - bits 0 and 1 also clear first-status
// - seek takes cylinder from bits 8:0
// - set offset takes magnitude bits 5:0
// - set offset bit6 picks direction
// - read, write, status codes return status
// - position returns sector and head bits
module disc_drive_tag_command_decoder #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              strobe,
  input  wire logic [3:0]        tag_lines,
  input  wire logic [15:0]       control_lines_in,
  output logic      [15:0]       control_lines_out,
  output logic                   control_lines_oe,
  input  wire logic [2:0]        unit_select,
  output logic                   unit_enabled,
  output logic      [5:0]        sector_addr,
  output logic      [1:0]        head_sel,
  output logic      [8:0]        target_cylinder,
  output logic                   seek_go,
  output logic      [5:0]        offset_mag,
  output logic                   offset_neg,
  output logic                   offset_go,
  output logic                   read_go,
  output logic                   write_go,
  output logic      [2:0]        attention,
  output logic                   first_status
);

  // ==========================================
  // state
  drive_cmd_pkg::drive_state_s r_reg;
  drive_cmd_pkg::drive_state_s r_next;

  logic strobe_rise;
  logic bus_req;
  logic bus_wr;
  logic evt_wr;
  logic pos_wr;
  logic [15:0] status_word;
  logic [15:0] position_word;
  logic returns_status;

  function automatic logic [15:0] make_word(input logic [5:0] sec,
                                            input logic [1:0] hd,
                                            input logic fst,
                                            input logic [2:0] at);
    logic [15:0] w;
    w = `RST_ZERO16;
    w[`CTL_SECTOR] = sec;
    w[`CTL_HEAD] = hd;
    w[`CTL_ST_FIRST] = fst;
    w[`CTL_ST_ATTN] = |at;
    return w;
  endfunction

  // only stage two and three feed the edge; stage one is sync only
  assign strobe_rise = r_reg.strobe_s2 & ~r_reg.strobe_s3;
  assign bus_req = wb_cyc_i & wb_stb_i & (r_reg.phase == drive_cmd_pkg::bus_idle);
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign evt_wr = bus_wr & (wb_adr_i == `REG_STATUS);
  assign pos_wr = bus_wr & (wb_adr_i == `REG_POSITION);
  assign status_word = make_word(6'h00, 2'h0, r_reg.first_status, r_reg.attention);
  assign position_word = make_word(r_reg.cur_sector, r_reg.head, 1'b0, r_reg.attention);
  assign returns_status = (r_reg.tag_s2 == `TAG_READ) | (r_reg.tag_s2 == `TAG_WRITE) |
                          (r_reg.tag_s2 == `TAG_STATUS);

  // ==========================================
  // next state
  always_comb begin
    r_next = r_reg;
    r_next.strobe_s1 = strobe;
    r_next.strobe_s2 = r_reg.strobe_s1;
    r_next.strobe_s3 = r_reg.strobe_s2;
    r_next.tag_s1 = tag_lines;
    r_next.tag_s2 = r_reg.tag_s1;
    r_next.ctl_s1 = control_lines_in;
    r_next.ctl_s2 = r_reg.ctl_s1;
    r_next.unit_s1 = unit_select;
    r_next.unit_s2 = r_reg.unit_s1;
    r_next.seek_go = 1'b0;
    r_next.offset_go = 1'b0;
    r_next.read_go = 1'b0;
    r_next.write_go = 1'b0;
    // tag and control settle before strobe, so two-flop delay keeps them aligned
    if (strobe_rise) begin
      if (r_reg.tag_s2 == `TAG_UNIT) begin
        r_next.selected = (r_reg.ctl_s2[`CTL_UNIT] == r_reg.unit_s2);
      end else if (r_reg.selected) begin
        case (r_reg.tag_s2)
          `TAG_RECORD: begin
            r_next.sector = r_reg.ctl_s2[`CTL_SECTOR];
            r_next.head = r_reg.ctl_s2[`CTL_HEAD];
          end
          `TAG_SEEK: begin
            r_next.cylinder = r_reg.ctl_s2[`CTL_CYL];
            r_next.seek_go = 1'b1;
          end
          `TAG_OFFSET: begin
            r_next.offset_mag = r_reg.ctl_s2[`CTL_OFS_MAG];
            r_next.offset_neg = r_reg.ctl_s2[`CTL_OFS_NEG];
            r_next.offset_go = 1'b1;
          end
          `TAG_CLEAR: begin
            if (r_reg.ctl_s2[`CTL_CLR_ATTN]) begin
              r_next.attention = 3'h0;
              if (r_reg.ctl_s2[`CTL_CLR_FIRST]) begin
                r_next.first_status = 1'b0;
              end
            end
          end
          `TAG_READ: r_next.read_go = 1'b1;
          // decoded even though the service tester never sends it
          `TAG_WRITE: r_next.write_go = 1'b1;
          default: ;
        endcase
      end
    end
    // events posted by software win over a clear in the same cycle
    if (evt_wr) begin
      r_next.attention = r_next.attention | wb_dat_i[`RF_ATTN];
      r_next.first_status = r_next.first_status | wb_dat_i[`RF_FIRST];
    end
    if (pos_wr) begin
      r_next.cur_sector = wb_dat_i[`CTL_SECTOR];
    end
    // answer only while strobe stays held by the controller
    r_next.ctl_oe = 1'b0;
    r_next.ctl_out = `RST_ZERO16;
    if (r_reg.strobe_s2 & r_reg.selected) begin
      if (returns_status) begin
        r_next.ctl_oe = 1'b1;
        r_next.ctl_out = status_word;
      end else if (r_reg.tag_s2 == `TAG_POSITION) begin
        r_next.ctl_oe = 1'b1;
        r_next.ctl_out = position_word;
      end
    end
    // wishbone: one wait state, ack for exactly one cycle
    case (r_reg.phase)
      drive_cmd_pkg::bus_idle: begin
        if (bus_req) begin
          r_next.phase = drive_cmd_pkg::bus_acked;
          r_next.dat_o = `RST_ZERO32;
          case (wb_adr_i)
            `REG_STATUS: begin
              r_next.dat_o[`RF_SELECTED] = r_reg.selected;
              r_next.dat_o[`RF_ATTN] = r_reg.attention;
              r_next.dat_o[`RF_FIRST] = r_reg.first_status;
            end
            `REG_ADDRESS: begin
              r_next.dat_o[`CTL_SECTOR] = r_reg.sector;
              r_next.dat_o[`CTL_HEAD] = r_reg.head;
            end
            `REG_SEEK: r_next.dat_o[`CTL_CYL] = r_reg.cylinder;
            `REG_OFFSET: begin
              r_next.dat_o[`CTL_OFS_MAG] = r_reg.offset_mag;
              r_next.dat_o[`CTL_OFS_NEG] = r_reg.offset_neg;
            end
            `REG_POSITION: r_next.dat_o[`CTL_SECTOR] = r_reg.cur_sector;
            default: ;
          endcase
        end
      end
      drive_cmd_pkg::bus_acked: r_next.phase = drive_cmd_pkg::bus_idle;
      default: r_next.phase = drive_cmd_pkg::bus_idle;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // outputs
  assign wb_dat_o = r_reg.dat_o;
  assign wb_ack_o = (r_reg.phase == drive_cmd_pkg::bus_acked);
  assign control_lines_out = r_reg.ctl_out;
  assign control_lines_oe = r_reg.ctl_oe;
  assign unit_enabled = r_reg.selected;
  assign sector_addr = r_reg.sector;
  assign head_sel = r_reg.head;
  assign target_cylinder = r_reg.cylinder;
  assign seek_go = r_reg.seek_go;
  assign offset_mag = r_reg.offset_mag;
  assign offset_neg = r_reg.offset_neg;
  assign offset_go = r_reg.offset_go;
  assign read_go = r_reg.read_go;
  assign write_go = r_reg.write_go;
  assign attention = r_reg.attention;
  assign first_status = r_reg.first_status;

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_unit_match: assert property (
    strobe_rise && r_reg.tag_s2 == `TAG_UNIT && r_reg.ctl_s2[`CTL_UNIT] == r_reg.unit_s2
    |=> unit_enabled) else $error("matching unit address did not enable");

  a_unit_miss: assert property (
    strobe_rise && r_reg.tag_s2 == `TAG_UNIT && r_reg.ctl_s2[`CTL_UNIT] != r_reg.unit_s2
    |=> !unit_enabled) else $error("foreign unit address left drive enabled");

  a_record_load: assert property (
    strobe_rise && r_reg.selected && r_reg.tag_s2 == `TAG_RECORD
    |=> sector_addr == $past(r_reg.ctl_s2[`CTL_SECTOR]) &&
        head_sel == $past(r_reg.ctl_s2[`CTL_HEAD])) else $error("record address not loaded");

  a_seek_load: assert property (
    strobe_rise && r_reg.selected && r_reg.tag_s2 == `TAG_SEEK
    |=> seek_go && target_cylinder == $past(r_reg.ctl_s2[`CTL_CYL]))
    else $error("seek not started with captured cylinder");

  a_offset_load: assert property (
    strobe_rise && r_reg.selected && r_reg.tag_s2 == `TAG_OFFSET
    |=> offset_go && offset_mag == $past(r_reg.ctl_s2[`CTL_OFS_MAG]) &&
        offset_neg == $past(r_reg.ctl_s2[`CTL_OFS_NEG])) else $error("offset not loaded");

  a_clear_attn: assert property (
    strobe_rise && r_reg.selected && r_reg.tag_s2 == `TAG_CLEAR &&
    r_reg.ctl_s2[`CTL_CLR_ATTN] && !evt_wr
    |=> attention == 3'h0) else $error("attention not cleared");

  a_clear_first: assert property (
    strobe_rise && r_reg.selected && r_reg.tag_s2 == `TAG_CLEAR &&
    r_reg.ctl_s2[`CTL_CLR_ATTN] && r_reg.ctl_s2[`CTL_CLR_FIRST] && !evt_wr
    |=> !first_status) else $error("first status not cleared");

  a_keep_first: assert property (
    strobe_rise && r_reg.tag_s2 == `TAG_CLEAR && !r_reg.ctl_s2[`CTL_CLR_FIRST] && !evt_wr
    |=> $stable(first_status)) else $error("first status cleared without bit 1");

  a_ignore_unsel: assert property (
    strobe_rise && !r_reg.selected && r_reg.tag_s2 != `TAG_UNIT
    |=> $stable(target_cylinder) && $stable(sector_addr) && !seek_go && !offset_go)
    else $error("unselected drive acted on command");

  a_once_strobe: assert property (
    seek_go |-> !$past(seek_go) && r_reg.strobe_s3)
    else $error("seek issued twice for one strobe");

  a_status_drive: assert property (
    r_reg.strobe_s2 && r_reg.selected && returns_status
    |=> control_lines_oe && control_lines_out == $past(status_word))
    else $error("status not returned on control lines");

  a_position_word: assert property (
    r_reg.strobe_s2 && r_reg.selected && r_reg.tag_s2 == `TAG_POSITION
    |=> control_lines_oe && control_lines_out[`CTL_SECTOR] == $past(r_reg.cur_sector) &&
        control_lines_out[`CTL_HEAD] == $past(r_reg.head)) else $error("bad position word");

  a_release_bus: assert property (
    !r_reg.strobe_s2 |=> !control_lines_oe) else $error("control lines driven after strobe");

  a_wb_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle after request");

endmodule // disc_drive_tag_command_decoder
`default_nettype wire

// [hw/drive_cmd_map.svh]
// constants for the tag bus command decoder and its register map
`ifndef DRIVE_CMD_MAP_SVH
`define DRIVE_CMD_MAP_SVH
// ==========================================
// tag codes
`define TAG_READ      4'h0
`define TAG_WRITE     4'h1
`define TAG_STATUS    4'h2
`define TAG_POSITION  4'h3
`define TAG_SEEK      4'h8
`define TAG_RECORD    4'h9
`define TAG_UNIT      4'ha
`define TAG_OFFSET    4'hd
`define TAG_CLEAR     4'he
// ==========================================
// control bus fields
`define CTL_SECTOR    5:0
`define CTL_HEAD      9:8
`define CTL_UNIT      2:0
`define CTL_CYL       8:0
`define CTL_OFS_MAG   5:0
`define CTL_OFS_NEG   6
`define CTL_CLR_ATTN  0
`define CTL_CLR_FIRST 1
`define CTL_ST_FIRST  3
`define CTL_ST_ATTN   7
// ==========================================
// register map, byte offsets
`define REG_STATUS    8'h00
`define REG_ADDRESS   8'h04
`define REG_SEEK      8'h08
`define REG_OFFSET    8'h0c
`define REG_POSITION  8'h10
`define RF_SELECTED   0
`define RF_ATTN       3:1
`define RF_FIRST      4
// ==========================================
// reset values
`define RST_ZERO16    16'h0000
`define RST_ZERO32    32'h0000_0000
`endif

// [hw/drive_cmd_pkg.sv]
// types shared by the tag bus command decoder
package drive_cmd_pkg;
  typedef enum logic [0:0] {bus_idle, bus_acked} bus_phase_e;
  typedef struct packed {
    logic        strobe_s1;
    logic        strobe_s2;
    logic        strobe_s3;
    logic [3:0]  tag_s1;
    logic [3:0]  tag_s2;
    logic [15:0] ctl_s1;
    logic [15:0] ctl_s2;
    logic [2:0]  unit_s1;
    logic [2:0]  unit_s2;
    logic        selected;
    logic [5:0]  sector;
    logic [1:0]  head;
    logic [8:0]  cylinder;
    logic [5:0]  offset_mag;
    logic        offset_neg;
    logic [2:0]  attention;
    logic        first_status;
    logic [5:0]  cur_sector;
    logic [15:0] ctl_out;
    logic        ctl_oe;
    logic        seek_go;
    logic        offset_go;
    logic        read_go;
    logic        write_go;
    bus_phase_e  phase;
    logic [31:0] dat_o;
  } drive_state_s;
endpackage

// [dv/tester_model.sv]
// controller-side model that presents tag commands to the drive
`timescale 1ns/1ps
`default_nettype none
module tester_model (
  input  wire logic        mclk,
  output var  logic        strobe,
  output var  logic [3:0]  tag_lines,
  output var  logic [15:0] control_lines
);
  initial begin
    strobe = 1'b0;
    tag_lines = 4'h0;
    control_lines = 16'h0000;
  end
  // ==========================================
  // one strobed command, code and parameters set up first
  task automatic issue(input logic [3:0] t, input logic [15:0] c);
    if (t !== 4'h1) begin
      @(posedge mclk);
      tag_lines <= t;
      control_lines <= c;
      repeat (4) @(posedge mclk);
      strobe <= 1'b1;
      // held well past one sync delay so a repeat would show
      repeat (6) @(posedge mclk);
      strobe <= 1'b0;
      repeat (3) @(posedge mclk);
      tag_lines <= ~t;
      control_lines <= ~c;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule // tester_model
`default_nettype wire

// [dv/disc_drive_tag_command_decoder_tb.sv]
// self-checking bench for the tag bus command decoder
`timescale 1ns/1ps
`default_nettype none
`include "drive_cmd_map.svh"
module disc_drive_tag_command_decoder_tb;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, oe_seen = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, strobe, oe, seek_go, rgo, ogo;
  logic [3:0]  tag;
  logic [15:0] ctl_drv, ctl_in, ctl_out, c;
  logic [2:0]  unit_sel = 3'h0;
  logic [1:0]  h;
  logic [5:0]  s;
  logic [31:0] rq[$], aq[$];
  int          fails = 0, cmp_count = 0, seeks = 0, reads = 0, offs = 0;

  always #4 mclk = ~mclk;
  // the drive's answer owns the shared bus while it drives
  assign ctl_in = oe ? ctl_out : ctl_drv;

  tester_model tester_model_i (.mclk(mclk), .strobe(strobe), .tag_lines(tag),
    .control_lines(ctl_drv));
  disc_drive_tag_command_decoder disc_drive_tag_command_decoder_i (
    .mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .strobe(strobe), .tag_lines(tag), .control_lines_in(ctl_in),
    .control_lines_out(ctl_out), .control_lines_oe(oe), .unit_select(unit_sel),
    .unit_enabled(), .sector_addr(), .head_sel(), .target_cylinder(),
    .seek_go(seek_go), .offset_mag(), .offset_neg(), .offset_go(ogo), .read_go(rgo),
    .write_go(), .attention(), .first_status());

  // ==========================================
  // checking and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // classic wishbone master
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // ack is read as it stood at the edge; release right after that edge
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  // outputs are settled mid-cycle; one-cycle results seen once
  always @(negedge mclk) begin
    if (ack === 1'b1 && !we) begin
      if (rq.size() > 0) check(rdat, rq.pop_front());
      else fails++;
    end
    if (oe === 1'b1 && !oe_seen) begin
      if (aq.size() > 0) check({16'h0, ctl_out}, aq.pop_front());
      else fails++;
    end
    oe_seen = (oe === 1'b1);
    if (seek_go === 1'b1) seeks++;
    if (rgo === 1'b1) reads++;
    if (ogo === 1'b1) offs++;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(6115));
    unit_sel <= 3'($urandom);
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rd(`REG_STATUS, 32'h0);
    tester_model_i.issue(`TAG_SEEK, 16'h01ff);
    rd(`REG_SEEK, 32'h0);
    tester_model_i.issue(`TAG_UNIT, {13'h0, unit_sel ^ 3'h5});
    rd(`REG_STATUS, 32'h0);
    c = 16'($urandom);
    c[2:0] = unit_sel;
    tester_model_i.issue(`TAG_UNIT, c);
    rd(`REG_STATUS, 32'h1);
    c = 16'($urandom);
    h = c[9:8];
    tester_model_i.issue(`TAG_RECORD, c);
    rd(`REG_ADDRESS, {22'h0, c[9:8], 2'h0, c[5:0]});
    c = 16'($urandom);
    tester_model_i.issue(`TAG_SEEK, c);
    rd(`REG_SEEK, {23'h0, c[8:0]});
    check(seeks, 32'h1);
    for (int i = 0; i < 2; i++) begin
      c = 16'($urandom);
      c[6] = i[0];
      tester_model_i.issue(`TAG_OFFSET, c);
      rd(`REG_OFFSET, {25'h0, c[6:0]});
    end
    check(offs, 32'h2);
    wb(1'b1, `REG_STATUS, 32'h1e);
    rd(`REG_STATUS, 32'h1f);
    aq.push_back(32'h88);
    tester_model_i.issue(`TAG_READ, 16'($urandom));
    check(reads, 32'h1);
    aq.push_back(32'h88);
    tester_model_i.issue(`TAG_STATUS, 16'($urandom));
    tester_model_i.issue(`TAG_CLEAR, 16'h0001);
    rd(`REG_STATUS, 32'h11);
    aq.push_back(32'h08);
    tester_model_i.issue(`TAG_STATUS, 16'h0000);
    tester_model_i.issue(`TAG_CLEAR, 16'h0003);
    rd(`REG_STATUS, 32'h1);
    s = 6'($urandom);
    wb(1'b1, `REG_POSITION, {26'h0, s});
    rd(`REG_POSITION, {26'h0, s});
    aq.push_back({22'h0, h, 2'h0, s});
    tester_model_i.issue(`TAG_POSITION, 16'h0000);
    rd(8'h20, 32'h0);
    // mid-run reset must drop the selection and all flags
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(`REG_STATUS, 32'h0);
    check(32'(rq.size() + aq.size()), 32'h0);
    conclude();
  end
endmodule // disc_drive_tag_command_decoder_tb
`default_nettype wire
